// file: ssi_cfg.svh
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// serial framing
`define SSI_BITS_PER_BYTE   4'h8
`define SSI_BIT_CNT_W       4
// power-up and trailing dummy bytes
`define SSI_PRE_DUMMY_BYTES 4'hA
`define SSI_POST_DUMMY_BYTES 4'h1
`define SSI_CMD_BYTES       4'h6
`define SSI_RESP_BYTES      4'h2
`define SSI_DUMMY_BYTE      8'hFF
// reset-to-idle command frame, leading byte first
`define SSI_CMD_BYTE0       8'h40
`define SSI_CMD_BYTE1       8'h00
`define SSI_CMD_BYTE2       8'h00
`define SSI_CMD_BYTE3       8'h00
`define SSI_CMD_BYTE4       8'h00
`define SSI_CMD_BYTE5       8'h95
`define SSI_IDLE_CODE       8'h01
// serial clock: half period in system clocks (100 MHz / 8 = 12.5 MHz)
`define SSI_HALF_PERIOD_NS  40
`define SSI_CLK_PERIOD_NS   10
`define SSI_HALF_CYCLES     ((`SSI_HALF_PERIOD_NS + `SSI_CLK_PERIOD_NS - 1) / `SSI_CLK_PERIOD_NS)
`define SSI_DIV_W           4

`endif

// file: ssi_pkg.sv
package ssi_pkg;
   typedef enum logic [2:0] {
      SSI_IDLE = 3'b000,
      SSI_PRE  = 3'b001,
      SSI_CMD  = 3'b010,
      SSI_RESP = 3'b011,
      SSI_POST = 3'b100
   } ssi_state_t;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic cs_n;
   } ssi_link_out_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic ok;
      logic fail;
   } ssi_status_t;
endpackage : ssi_pkg

// file: ssi_card_init.sv
`timescale 1ns/100ps
`include "ssi_cfg.svh"

// Overview of operation
// - eight bit bytes, most significant first
// - shift out after fall, sample on rise
// - ten dummy bytes, select high, output one
// - select low, send six command bytes
// - leading command byte is 0x40
// - read two bytes, keep only second
// - correct answer is 0x01
// - raise select, one more dummy byte
module ssi_card_init (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  start,
   input  wire logic                  miso,
   output ssi_pkg::ssi_link_out_t     link_out,
   output ssi_pkg::ssi_status_t       status
);
   ssi_pkg::ssi_state_t state_reg, state_next;
   logic [`SSI_DIV_W-1:0]     div_reg;
   logic                      sclk_reg;
   logic [`SSI_BIT_CNT_W-1:0] bit_reg;
   logic [3:0]                byte_reg;
   logic [7:0]                tx_reg;
   logic [7:0]                rx_reg;
   logic                      cs_n_reg;
   logic                      ok_reg;
   logic                      fail_reg;
   logic                      done_reg;
   logic                      miso_s1_reg;
   logic                      miso_s2_reg;

   function automatic logic [7:0] cmd_byte(input logic [3:0] idx);
      case (idx)
         4'h0:    cmd_byte = `SSI_CMD_BYTE0;
         4'h1:    cmd_byte = `SSI_CMD_BYTE1;
         4'h2:    cmd_byte = `SSI_CMD_BYTE2;
         4'h3:    cmd_byte = `SSI_CMD_BYTE3;
         4'h4:    cmd_byte = `SSI_CMD_BYTE4;
         default: cmd_byte = `SSI_CMD_BYTE5;
      endcase
   endfunction : cmd_byte

   wire active     = (state_reg != ssi_pkg::SSI_IDLE);
   wire half_tick  = active && (div_reg == `SSI_DIV_W'(`SSI_HALF_CYCLES - 1));
   wire rise       = half_tick && !sclk_reg;
   wire fall       = half_tick && sclk_reg;
   wire byte_end   = fall && (bit_reg == `SSI_BITS_PER_BYTE - 4'h1);
   wire [3:0] byte_limit =
      (state_reg == ssi_pkg::SSI_PRE)  ? `SSI_PRE_DUMMY_BYTES :
      (state_reg == ssi_pkg::SSI_CMD)  ? `SSI_CMD_BYTES :
      (state_reg == ssi_pkg::SSI_RESP) ? `SSI_RESP_BYTES : `SSI_POST_DUMMY_BYTES;
   wire phase_end  = byte_end && (byte_reg == byte_limit - 4'h1);
   wire [7:0] next_byte_cmd = cmd_byte(byte_reg + 4'h1);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ssi_pkg::SSI_IDLE: if (start) state_next = ssi_pkg::SSI_PRE;
         ssi_pkg::SSI_PRE:  if (phase_end) state_next = ssi_pkg::SSI_CMD;
         ssi_pkg::SSI_CMD:  if (phase_end) state_next = ssi_pkg::SSI_RESP;
         ssi_pkg::SSI_RESP: if (phase_end) state_next = ssi_pkg::SSI_POST;
         ssi_pkg::SSI_POST: if (phase_end) state_next = ssi_pkg::SSI_IDLE;
         default:           state_next = ssi_pkg::SSI_IDLE;
      endcase
   end

   // miso crosses in from the card
   always_ff @(posedge clk) begin
      miso_s1_reg <= miso;
      miso_s2_reg <= miso_s1_reg;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ssi_pkg::SSI_IDLE;
         div_reg   <= '0;
         sclk_reg  <= 1'b0;
         bit_reg   <= '0;
         byte_reg  <= '0;
         tx_reg    <= `SSI_DUMMY_BYTE;
         rx_reg    <= '0;
         cs_n_reg  <= 1'b1;
         ok_reg    <= 1'b0;
         fail_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg  <= 1'b0;
         div_reg   <= (half_tick || !active) ? '0 : div_reg + `SSI_DIV_W'(1);
         if (half_tick) begin
            sclk_reg <= !sclk_reg;
         end
         if (state_reg == ssi_pkg::SSI_IDLE && start) begin
            byte_reg <= '0;
            bit_reg  <= '0;
            tx_reg   <= `SSI_DUMMY_BYTE;
            ok_reg   <= 1'b0;
         end
         if (rise) begin
            rx_reg <= {rx_reg[6:0], miso_s2_reg};
         end
         if (fall) begin
            bit_reg <= bit_reg + 4'h1;
            tx_reg  <= {tx_reg[6:0], 1'b1};
         end
         if (byte_end) begin
            bit_reg  <= '0;
            byte_reg <= phase_end ? 4'h0 : byte_reg + 4'h1;
            tx_reg   <= `SSI_DUMMY_BYTE;
            if (state_reg == ssi_pkg::SSI_PRE && phase_end) begin
               cs_n_reg <= 1'b0;
               tx_reg   <= `SSI_CMD_BYTE0;
            end
            if (state_reg == ssi_pkg::SSI_CMD && !phase_end) begin
               tx_reg <= next_byte_cmd;
            end
            if (state_reg == ssi_pkg::SSI_RESP && phase_end) begin
               cs_n_reg <= 1'b1;
               if (rx_reg == `SSI_IDLE_CODE) begin
                  ok_reg <= 1'b1;
               end else begin
                  fail_reg <= 1'b1;
               end
            end
            if (state_reg == ssi_pkg::SSI_POST) begin
               done_reg <= 1'b1;
               sclk_reg <= 1'b0;
            end
         end
      end
   end

   assign link_out.sclk = sclk_reg;
   assign link_out.mosi = tx_reg[7];
   assign link_out.cs_n = cs_n_reg;
   assign status.busy   = active;
   assign status.done   = done_reg;
   assign status.ok     = ok_reg;
   assign status.fail   = fail_reg;

   property p_pre_cs_high;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_PRE) |-> (link_out.cs_n && link_out.mosi);
   endproperty
   a_pre_cs_high: assert property (p_pre_cs_high) else $error("select low in pre");

   property p_post_cs_high;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_POST) |-> (link_out.cs_n && link_out.mosi);
   endproperty
   a_post_cs_high: assert property (p_post_cs_high) else $error("select low in post");

   property p_cmd_cs_low;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_CMD) |-> !link_out.cs_n;
   endproperty
   a_cmd_cs_low: assert property (p_cmd_cs_low) else $error("select high in cmd");

   property p_first_cmd;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_PRE && phase_end) |=> (tx_reg == `SSI_CMD_BYTE0);
   endproperty
   a_first_cmd: assert property (p_first_cmd) else $error("bad lead byte");

   property p_mosi_on_fall;
      @(posedge clk) disable iff (reset)
      (active && !fall && !(state_reg == ssi_pkg::SSI_IDLE)) |=> $stable(link_out.mosi) || $past(fall);
   endproperty
   a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("mosi moved off edge");

   property p_fail_sticky;
      @(posedge clk) disable iff (reset)
      status.fail |=> status.fail;
   endproperty
   a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag dropped");

   property p_verdict;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_RESP && phase_end && rx_reg == `SSI_IDLE_CODE) |=> status.ok;
   endproperty
   a_verdict: assert property (p_verdict) else $error("idle code not accepted");

   sequence s_post_end;
      (state_reg == ssi_pkg::SSI_POST) && phase_end;
   endsequence
   property p_done;
      @(posedge clk) disable iff (reset)
      s_post_end |=> (status.done && !status.busy) ##1 !status.done;
   endproperty
   a_done: assert property (p_done) else $error("done not pulsed");

   property p_byte_len;
      @(posedge clk) disable iff (reset)
      active |-> (bit_reg < `SSI_BITS_PER_BYTE);
   endproperty
   a_byte_len: assert property (p_byte_len) else $error("bit count past byte");

   property p_pre_count;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_PRE) |-> (byte_reg < `SSI_PRE_DUMMY_BYTES);
   endproperty
   a_pre_count: assert property (p_pre_count) else $error("too many dummy bytes");

   property p_resp_lines;
      @(posedge clk) disable iff (reset)
      (state_reg == ssi_pkg::SSI_RESP) |-> (!link_out.cs_n && link_out.mosi);
   endproperty
   a_resp_lines: assert property (p_resp_lines) else $error("bad lines in response");

   sequence s_resp_bad;
      (state_reg == ssi_pkg::SSI_RESP) && phase_end && (rx_reg != `SSI_IDLE_CODE);
   endsequence
   property p_reject;
      @(posedge clk) disable iff (reset)
      s_resp_bad |=> (status.fail && !status.ok && link_out.cs_n);
   endproperty
   a_reject: assert property (p_reject) else $error("wrong answer not flagged");

   property p_sclk_idle;
      @(posedge clk) disable iff (reset)
      !active |-> !link_out.sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock not idle low");

   property p_start_busy;
      @(posedge clk) disable iff (reset)
      (!status.busy && start) |=> status.busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start not taken");
endmodule : ssi_card_init

// file: ssi_card_model.sv
`timescale 1ns/100ps
module ssi_card_model (
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       cs_n,
   input  wire logic [7:0] resp0,
   input  wire logic [7:0] resp1,
   output wire logic       miso
);
   int          rx_bits = 0;
   logic [15:0] tx_reg  = 16'hFFFF;
   logic        bit_reg = 1'b1;
   always @(posedge sclk) begin
      if (!cs_n) begin
         rx_bits = rx_bits + 1;
         if (rx_bits == 48) begin
            tx_reg = {resp0, resp1};
         end
      end
   end
   always @(negedge sclk) begin
      if (!cs_n && rx_bits >= 48) begin
         bit_reg = tx_reg[15];
         tx_reg  = {tx_reg[14:0], 1'b1};
      end
   end
   always @(posedge cs_n) rx_bits = 0;
   // deselected line must not look like a held bit
   assign miso = cs_n ? ~bit_reg : bit_reg;
endmodule : ssi_card_model

// file: ssi_card_init_tb.sv
`timescale 1ns/100ps
module ssi_card_init_tb;
   logic                   clk = 0, reset = 1, start = 0, fail_exp = 0;
   logic [7:0]             resp0 = 8'hFF, resp1 = 8'h01, sh;
   wire logic              miso;
   ssi_pkg::ssi_link_out_t link_out;
   ssi_pkg::ssi_status_t   status;
   int                     fail_count = 0, checked = 0, nbits = 0;
   logic                   cs_first;
   logic [8:0]             seen_q[$];
   logic [7:0]             cmd[6] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h95};
   initial forever #5 clk = ~clk;
   ssi_card_init u_ssi_card_init (.clk(clk), .reset(reset), .start(start), .miso(miso),
      .link_out(link_out), .status(status));
   ssi_card_model u_ssi_card_model (.sclk(link_out.sclk), .mosi(link_out.mosi),
      .cs_n(link_out.cs_n), .resp0(resp0), .resp1(resp1), .miso(miso));
   always @(posedge link_out.sclk or posedge reset) begin
      if (reset) begin
         nbits = 0;
      end else begin
         if (nbits == 0) cs_first = link_out.cs_n;
         sh = {sh[6:0], link_out.mosi};
         nbits++;
         if (nbits == 8) begin
            seen_q.push_back({cs_first, sh});
            nbits = 0;
         end
      end
   end
   task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask : check
   task results;
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   task run(input logic [7:0] r0, input logic [7:0] ans);
      int         n;
      logic [8:0] e;
      resp0 = r0;
      resp1 = ans;
      seen_q.delete();
      fail_exp = fail_exp | (ans !== 8'h01);
      @(negedge clk) start = 1;
      @(negedge clk) start = 0;
      check("busy", 9'(status.busy), 9'h001);
      check("ok cleared", 9'(status.ok), 9'h000);
      // a second request mid-run must change nothing
      repeat (100) @(negedge clk);
      start = 1;
      @(negedge clk) start = 0;
      n = 0;
      while (status.done !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n == 3000) begin
         fail_count++;
         results();
      end
      check("busy at done", 9'(status.busy), 9'h000);
      check("bytes", 9'(seen_q.size()), 9'h013);
      for (n = 0; n < 19 && n < seen_q.size(); n++) begin
         e = {(n < 10 || n > 17), (n >= 10 && n < 16) ? cmd[(n + 2) % 6] : 8'hFF};
         check("byte", seen_q[n], e);
         if (n == 10) check("lead", seen_q[n], 9'h040);
         if (n > 9 && n < 16) check("frame", seen_q[n], e);
         if (n == 18) check("trail", seen_q[n], 9'h1FF);
      end
      check("ok", 9'(status.ok), 9'(ans == 8'h01));
      check("fail", 9'(status.fail), 9'(fail_exp));
      @(negedge clk);
      check("done pulse", 9'(status.done), 9'h000);
      check("idle", 9'({link_out.cs_n, link_out.sclk}), 9'h002);
   endtask : run
   initial begin
      logic [7:0] bad;
      void'($urandom(63110));
      repeat (10) @(negedge clk);
      reset = 0;
      check("reset", 9'({link_out.cs_n, link_out.mosi, status}), 9'h030);
      run(8'($urandom), 8'h01);
      bad = 8'($urandom);
      if (bad == 8'h01) bad = 8'h02;
      // first byte carries the idle code and must be ignored
      run(8'h01, bad);
      run(8'($urandom), 8'h01);
      // reset in the middle of the command frame
      @(negedge clk) start = 1;
      @(negedge clk) start = 0;
      repeat (800) @(negedge clk);
      check("select in frame", 9'(link_out.cs_n), 9'h000);
      reset = 1;
      repeat (10) @(negedge clk);
      reset = 0;
      check("reset again", 9'({link_out.cs_n, link_out.mosi, status}), 9'h030);
      fail_exp = 0;
      run(8'($urandom), 8'h01);
      results();
   end
endmodule : ssi_card_init_tb
